// [inc/tgc_pkg.sv]
/*
  package of the timeout guard counter: register offsets, field layout,
  reset values, feed sequence words and the tick source select.
  assumes a single core clock domain and a plain strobe register port.
*/
`default_nettype none
// How it works
// (R01) the counter is 24 bits and advances only on every fourth tick clock edge.
// (R02) each prescaled tick takes one away from the counter.
// (R03) a reload value below 0xff is replaced by 0xff when loaded.
// (R04) the interval thus spans 256 to 2**24 prescaled ticks in steps of one.
// (R05) while enabled, an expired counter raises a system reset request in reset mode, otherwise a maskable interrupt.
// (R06) software can set enable, and only a reset or a timeout or feed fault clears it.
// (R07) while enabled, a wrong or broken feed sequence is a fault giving reset or interrupt.
// (R08) a readable flag records that the last reset came from this block.
// (R09) the tick is the internal 2 MHz clock or the external clock, per the select setting.
// (R10) software feeds with two fixed words on consecutive accesses; anything between faults.
package tgc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0]  ADDR_MODE    = 8'h00;
  localparam logic [7:0]  ADDR_RELOAD  = 8'h04;
  localparam logic [7:0]  ADDR_FEED    = 8'h08;
  localparam logic [7:0]  ADDR_COUNT   = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS  = 8'h10;
  localparam logic [7:0]  ADDR_MASK    = 8'h14;
  localparam logic [7:0]  ADDR_CLKSEL  = 8'h18;
  // ==========================================================
  // field positions of the mode register
  localparam int          MODE_EN_BIT    = 0;
  localparam int          MODE_RESET_BIT = 1;
  localparam int          MODE_FLAG_BIT  = 2;
  // status bits: timeout and feed fault events
  localparam int          ST_TIMEOUT_BIT = 0;
  localparam int          ST_FAULT_BIT   = 1;
  localparam int          ST_W           = 2;
  // ==========================================================
  // counter geometry and values
  localparam int          CNT_W          = 24;
  localparam logic [23:0] RELOAD_MIN     = 24'h0000ff;
  localparam logic [23:0] RELOAD_RST     = 24'h0000ff;
  localparam logic [1:0]  PRESCALE_LAST  = 2'h3;
  localparam logic [7:0]  FEED_FIRST     = 8'haa;
  localparam logic [7:0]  FEED_SECOND    = 8'h55;
  // ==========================================================
  typedef enum logic {TGC_SRC_INT_OSC, TGC_SRC_EXT_CLK} tgc_src_t;
  typedef enum {TGC_FEED_IDLE, TGC_FEED_ARMED} tgc_feed_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tgc_req_t;
endpackage : tgc_pkg
`default_nettype wire

// [rtl/tgc_timeout_guard.sv]
/*
  timeout guard counter: prescaled 24-bit down counter that requests a
  system reset or an interrupt when not fed in time or fed wrongly.
  assumes: core_clk 10 MHz; the tick clocks arrive as asynchronous levels
  and are sampled here; the reset cause flag input is a level that the
  system holds stable while rst is high and after release.

  register port: one-cycle write strobe with address and data, one-cycle
  read strobe with address, read data registered and shown only in the
  cycle after the read strobe, zero in every other cycle.

  register layout:
    mode   : enable (write one sets), reset mode (1 = system reset,
             0 = interrupt only, writable only while disabled), reset
             cause flag (read; write one clears)
    reload : 24-bit reload value, clamped to the minimum when loaded
    feed   : two fixed words on consecutive accesses reload the counter
    count  : live counter value (read only)
    status : timeout and feed fault, sticky, cleared by a read
    mask   : same layout as status, enables the interrupt
    clksel : tick source, internal oscillator or external clock

  limitations: tick clocks must stay well below half the core clock, or
  edges are lost in the synchronisers and the guard runs slow.
*/
// Our own choices: the register addresses and the strobed register port.
`default_nettype none
module tgc_timeout_guard (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        int_osc_tick_clk,
  input  wire logic        ext_tick_clk,
  input  wire logic        reset_by_guard,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             sys_reset_req,
  output logic             irq
);
  // ==========================================================
  // request bundle
  tgc_pkg::tgc_req_t req;
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // ==========================================================
  // tick source synchronisers
  // two flops per source; nothing but the second flop is read, so a
  // metastable first stage never reaches the edge detector
  localparam int N_SRC = 2;
  wire logic [N_SRC-1:0] tick_pin = {ext_tick_clk, int_osc_tick_clk};
  logic      [N_SRC-1:0] tick_sync;
  genvar si;
  generate
    for (si = 0; si < N_SRC; si = si + 1) begin : g_sync
      logic [1:0] sync_ff;
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync_ff <= 2'h0;
        end else begin
          sync_ff <= {sync_ff[0], tick_pin[si]};
        end
      end
      assign tick_sync[si] = sync_ff[1];
    end
  endgenerate

  logic       tick_last_ff;

  // ==========================================================
  // tick source select
  // switching the source may give one stray edge; that costs at most one
  // prescaler step, which is far below the minimum interval
  tgc_pkg::tgc_src_t src_ff;
  wire logic tick_lvl  = (src_ff == tgc_pkg::TGC_SRC_EXT_CLK) ?
                         tick_sync[1] : tick_sync[0];  // see (R09)
  wire logic tick_rise = tick_lvl & ~tick_last_ff;

  // ==========================================================
  // prescaler: one enable pulse every fourth tick edge
  logic [1:0] pre_ff;
  wire logic  pre_tick = tick_rise && (pre_ff == tgc_pkg::PRESCALE_LAST);  // see (R01)

  // ==========================================================
  // register decode
  wire logic wr_mode   = req.wr && (req.addr == tgc_pkg::ADDR_MODE);
  wire logic wr_reload = req.wr && (req.addr == tgc_pkg::ADDR_RELOAD);
  wire logic wr_feed   = req.wr && (req.addr == tgc_pkg::ADDR_FEED);
  wire logic wr_mask   = req.wr && (req.addr == tgc_pkg::ADDR_MASK);
  wire logic wr_clksel = req.wr && (req.addr == tgc_pkg::ADDR_CLKSEL);
  wire logic rd_status = req.rd && (req.addr == tgc_pkg::ADDR_STATUS);

  logic                         en_ff;
  logic                         rst_mode_ff;
  logic                         flag_ff;
  logic [tgc_pkg::CNT_W-1:0]    reload_ff;
  logic [tgc_pkg::CNT_W-1:0]    cnt_ff;
  logic [tgc_pkg::ST_W-1:0]     status_ff;
  logic [tgc_pkg::ST_W-1:0]     mask_ff;
  logic                         sysrst_ff;
  logic                         flag_seen_ff;
  tgc_pkg::tgc_feed_t           feed_ff;

  // ==========================================================
  // feed sequence
  wire logic feed_first  = wr_feed && (req.wdata[7:0] == tgc_pkg::FEED_FIRST);
  wire logic feed_second = wr_feed && (req.wdata[7:0] == tgc_pkg::FEED_SECOND);
  wire logic armed       = (feed_ff == tgc_pkg::TGC_FEED_ARMED);
  // any access while armed other than the closing word breaks the sequence
  wire logic any_access  = req.wr || req.rd;
  wire logic feed_ok     = armed && feed_second;  // see (R10)
  wire logic feed_bad    = en_ff && ((armed && any_access && !feed_second) ||
                                     (!armed && wr_feed && !feed_first));  // see (R07)
  wire logic expire      = en_ff && pre_tick && (cnt_ff == '0);  // see (R05)
  wire logic guard_event = expire || feed_bad;

  // reload clamp: never start below the minimum
  wire logic [tgc_pkg::CNT_W-1:0] reload_clamped =
      (reload_ff < tgc_pkg::RELOAD_MIN) ? tgc_pkg::RELOAD_MIN : reload_ff;  // see (R03)
  wire logic [tgc_pkg::CNT_W-1:0] wr_reload_val = req.wdata[tgc_pkg::CNT_W-1:0];

  // ==========================================================
  // next state
  logic [tgc_pkg::CNT_W-1:0] nxt_cnt;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (feed_ok || !en_ff) begin
      nxt_cnt = reload_clamped;
    end else if (pre_tick && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 24'h000001;  // see (R02) (R04)
    end
  end

  // ==========================================================
  // feed sequence state
  // the armed state waits for the next access of any kind, however many
  // idle cycles pass first; only an access decides whether the feed completes
  tgc_pkg::tgc_feed_t nxt_feed;
  always_comb begin
    nxt_feed = feed_ff;
    case (feed_ff)
      tgc_pkg::TGC_FEED_IDLE: begin
        if (feed_first) begin
          nxt_feed = tgc_pkg::TGC_FEED_ARMED;
        end else begin
          nxt_feed = tgc_pkg::TGC_FEED_IDLE;
        end
      end
      tgc_pkg::TGC_FEED_ARMED: begin
        if (any_access) begin
          nxt_feed = tgc_pkg::TGC_FEED_IDLE;  // see (R07)
        end else begin
          nxt_feed = tgc_pkg::TGC_FEED_ARMED;
        end
      end
      default: begin
        nxt_feed = tgc_pkg::TGC_FEED_IDLE;
      end
    endcase
  end

  // ==========================================================
  // status: events set, a read clears, a set in the same cycle wins
  // the set must win so that an event landing on the clearing read is not lost
  wire logic [tgc_pkg::ST_W-1:0] st_set = {feed_bad, expire};
  logic      [tgc_pkg::ST_W-1:0] nxt_status;
  genvar gi;
  generate
    for (gi = 0; gi < tgc_pkg::ST_W; gi = gi + 1) begin : g_status
      assign nxt_status[gi] = st_set[gi] | (status_ff[gi] & ~rd_status);
    end
  endgenerate

  // ==========================================================
  // prescaler and reset request next values
  // the prescaler moves only on a tick edge, so a stopped tick clock stalls
  // the guard instead of letting it run on the core clock
  wire logic [1:0] nxt_pre    = tick_rise ? (pre_ff + 2'h1) : pre_ff;  // see (R01)
  // reset mode: the request is held until the system resets this block, so
  // even a one-cycle guard event leaves a full-length reset behind
  wire logic       nxt_sysrst = sysrst_ff || (guard_event && rst_mode_ff);  // see (R05) (R07)

  // ==========================================================
  // counter registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_last_ff <= 1'b0;
      pre_ff       <= 2'h0;
      cnt_ff       <= tgc_pkg::RELOAD_RST;
      feed_ff      <= tgc_pkg::TGC_FEED_IDLE;
      status_ff    <= '0;
      sysrst_ff    <= 1'b0;
    end else begin
      tick_last_ff <= tick_lvl;
      pre_ff       <= nxt_pre;
      cnt_ff       <= nxt_cnt;
      feed_ff      <= nxt_feed;
      status_ff    <= nxt_status;
      sysrst_ff    <= nxt_sysrst;
    end
  end

  // ==========================================================
  // control registers
  // enable is write-one only; a guard event drops it and beats a write in
  // the same cycle, so software cannot hide a fault by re-enabling
  wire logic mode_en_wr   = wr_mode && req.wdata[tgc_pkg::MODE_EN_BIT];
  wire logic mode_clr_wr  = wr_mode && req.wdata[tgc_pkg::MODE_FLAG_BIT];
  wire logic nxt_en       = guard_event ? 1'b0 : (en_ff || mode_en_wr);  // see (R06)
  // the reset mode is frozen while enabled, so a running guard cannot be
  // turned into a harmless interrupt-only guard
  wire logic nxt_rst_mode = (wr_mode && !en_ff) ? req.wdata[tgc_pkg::MODE_RESET_BIT]
                                                : rst_mode_ff;
  wire logic [tgc_pkg::CNT_W-1:0] nxt_reload = wr_reload ? wr_reload_val : reload_ff;
  wire logic [tgc_pkg::ST_W-1:0]  nxt_mask   = wr_mask ? req.wdata[tgc_pkg::ST_W-1:0]
                                                       : mask_ff;
  tgc_pkg::tgc_src_t              nxt_src;
  assign nxt_src = wr_clksel ? tgc_pkg::tgc_src_t'(req.wdata[0]) : src_ff;  // see (R09)

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_ff       <= 1'b0;
      rst_mode_ff <= 1'b0;
      reload_ff   <= tgc_pkg::RELOAD_RST;
      mask_ff     <= '0;
      src_ff      <= tgc_pkg::TGC_SRC_INT_OSC;
    end else begin
      en_ff       <= nxt_en;
      rst_mode_ff <= nxt_rst_mode;
      reload_ff   <= nxt_reload;
      mask_ff     <= nxt_mask;
      src_ff      <= nxt_src;
    end
  end

  // ==========================================================
  // reset cause flag
  // caught on the first clock after release, cleared by writing one; the
  // cause input is trusted only once, because the system may drop it later
  wire logic nxt_flag = !flag_seen_ff ? reset_by_guard
                                      : (mode_clr_wr ? 1'b0 : flag_ff);  // see (R08)

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_ff      <= 1'b0;
      flag_seen_ff <= 1'b0;
    end else begin
      flag_seen_ff <= 1'b1;
      flag_ff      <= nxt_flag;
    end
  end

  // ==========================================================
  // read data, one cycle after the read strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (req.addr)
      tgc_pkg::ADDR_MODE:   rd_mux = {29'h0, flag_ff, rst_mode_ff, en_ff};  // see (R08)
      tgc_pkg::ADDR_RELOAD: rd_mux = {8'h00, reload_ff};
      tgc_pkg::ADDR_COUNT:  rd_mux = {8'h00, cnt_ff};
      tgc_pkg::ADDR_STATUS: rd_mux = {30'h0, status_ff};
      tgc_pkg::ADDR_MASK:   rd_mux = {30'h0, mask_ff};
      tgc_pkg::ADDR_CLKSEL: rd_mux = {31'h0, src_ff};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  // data stand only in the answer cycle, so a stale value is never mistaken
  // for a fresh read
  wire logic [31:0] nxt_rdata = req.rd ? rd_mux : 32'h00000000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  // ==========================================================
  // outputs
  assign sys_reset_req = sysrst_ff;
  assign irq           = |(status_ff & mask_ff);
endmodule : tgc_timeout_guard
`default_nettype wire

// [verif/tgc_timeout_guard_monitor.sv]
/* port checker of the timeout guard counter.
   assumes one core_clk domain and the strobe register port. */
`default_nettype none
module tgc_timeout_guard_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        int_osc_tick_clk,
  input wire logic        ext_tick_clk,
  input wire logic        reset_by_guard,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        sys_reset_req,
  input wire logic        irq
);
  logic [1:0] mask_sh_ff;
  // mask reset value is not known here, so start permissive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) mask_sh_ff <= 2'h3;
    else if (reg_wr && reg_addr == tgc_pkg::ADDR_MASK) mask_sh_ff <= reg_wdata[1:0];
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED: assert property (
    reg_rd && reg_addr > tgc_pkg::ADDR_CLKSEL |=> reg_rdata == 32'h0)
    else $error("unmapped read gave data");
  AST_COUNT_W: assert property (
    reg_rd && reg_addr == tgc_pkg::ADDR_COUNT |=> reg_rdata[31:24] == 8'h0)
    else $error("count wider than 24 bits");
  AST_STATUS_W: assert property (
    reg_rd && reg_addr == tgc_pkg::ADDR_STATUS |=> reg_rdata[31:2] == 30'h0)
    else $error("status has stray bits");
  AST_MODE_W: assert property (
    reg_rd && reg_addr == tgc_pkg::ADDR_MODE |=> reg_rdata[31:3] == 29'h0)
    else $error("mode has stray bits");
  AST_SRR_STICKY: assert property (!$fell(sys_reset_req))
    else $error("reset request dropped without reset");
  AST_IRQ_MASKED: assert property (mask_sh_ff == 2'h0 |-> !irq)
    else $error("interrupt with all events masked");
  AST_QUIET_START: assert property ($fell(rst) |-> (!sys_reset_req && !irq)[*2])
    else $error("outputs active right after reset");
endmodule : tgc_timeout_guard_monitor
bind tgc_timeout_guard tgc_timeout_guard_monitor u_mon (.core_clk(core_clk), .rst(rst),
  .int_osc_tick_clk(int_osc_tick_clk), .ext_tick_clk(ext_tick_clk),
  .reset_by_guard(reset_by_guard), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sys_reset_req(sys_reset_req), .irq(irq));
`default_nettype wire

// [verif/tb_top.sv]
/* self-checking bench of the timeout guard counter.
   assumes the design package and a 10 MHz core clock. */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        int_osc_tick_clk = 1'b0;
  logic        ext_tick_clk = 1'b0;
  logic        reset_by_guard = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        sys_reset_req;
  logic        irq;
  logic [31:0] d;
  logic [31:0] e;
  int          n;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #50 core_clk = ~core_clk;
  // tick clocks offset so their edges never meet core_clk edges
  initial #13 forever #250 int_osc_tick_clk = ~int_osc_tick_clk;
  initial #29 forever #200 ext_tick_clk = ~ext_tick_clk;
  tgc_timeout_guard DUT (.core_clk(core_clk), .rst(rst), .int_osc_tick_clk(int_osc_tick_clk),
    .ext_tick_clk(ext_tick_clk), .reset_by_guard(reset_by_guard), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sys_reset_req(sys_reset_req), .irq(irq));
  // ==========================================================
  // tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rdc
  task automatic wait_hi(input logic use_srr, input int lim);
    n = 0;
    while ((use_srr ? sys_reset_req : irq) !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim) begin
      n_mismatch++;
      finish_test();
    end
  endtask : wait_hi
  task automatic do_reset(input logic flag);
    reset_by_guard <= flag;
    rst            <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
  endtask : do_reset
  // ==========================================================
  // tests
  initial begin
    do_reset(1'b0);
    rdc(tgc_pkg::ADDR_MODE, 32'h0);
    rdc(tgc_pkg::ADDR_COUNT, 32'hff);
    rdc(tgc_pkg::ADDR_CLKSEL, 32'h0);
    rdc(8'h1c, 32'h0);
    wr(tgc_pkg::ADDR_RELOAD, 32'h10);
    rdc(tgc_pkg::ADDR_COUNT, 32'hff);
    wr(tgc_pkg::ADDR_RELOAD, 32'h100);
    rdc(tgc_pkg::ADDR_COUNT, 32'h100);
    $display("test reset_and_clamp done");
    wr(tgc_pkg::ADDR_MODE, 32'h1);
    wr(tgc_pkg::ADDR_MODE, 32'h0);
    rdc(tgc_pkg::ADDR_MODE, 32'h1);
    rd(tgc_pkg::ADDR_COUNT, d);
    repeat (200) @(posedge core_clk);
    rd(tgc_pkg::ADDR_COUNT, e);
    chk({31'h0, (d - e) inside {[9:11]}}, 32'h1);
    wr(tgc_pkg::ADDR_FEED, 32'haa);
    wr(tgc_pkg::ADDR_FEED, 32'h55);
    rd(tgc_pkg::ADDR_COUNT, d);
    chk({31'h0, d inside {[32'hff:32'h100]}}, 32'h1);
    rdc(tgc_pkg::ADDR_STATUS, 32'h0);
    $display("test countdown_and_feed done");
    wr(tgc_pkg::ADDR_MASK, 32'h0);
    wr(tgc_pkg::ADDR_FEED, 32'haa);
    rd(tgc_pkg::ADDR_MODE, d);
    chk({31'h0, irq}, 32'h0);
    wr(tgc_pkg::ADDR_MASK, 32'h3);
    #1 chk({31'h0, irq}, 32'h1);
    rdc(tgc_pkg::ADDR_STATUS, 32'h2);
    rdc(tgc_pkg::ADDR_MODE, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test broken_feed done");
    wr(tgc_pkg::ADDR_RELOAD, 32'h0);
    wr(tgc_pkg::ADDR_MODE, 32'h1);
    wait_hi(1'b0, 6000);
    chk({31'h0, n inside {[5090:5135]}}, 32'h1);
    rdc(tgc_pkg::ADDR_STATUS, 32'h1);
    $display("test timeout_interrupt done");
    wr(tgc_pkg::ADDR_CLKSEL, 32'h1);
    wr(tgc_pkg::ADDR_MODE, 32'h3);
    wait_hi(1'b1, 5000);
    chk({31'h0, n inside {[4070:4110]}}, 32'h1);
    do_reset(1'b1);
    chk({31'h0, sys_reset_req}, 32'h0);
    rdc(tgc_pkg::ADDR_MODE, 32'h4);
    wr(tgc_pkg::ADDR_MODE, 32'h4);
    rdc(tgc_pkg::ADDR_MODE, 32'h0);
    $display("test timeout_reset done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
